// >>> design/lcd_bias_power_sequencer.sv
// Power-up sequencer for an LCD bias supply: buck, reset pulse, negative pump,
// isolation switch, source rail check, boost and positive pump hand-over.
// Assumes converter status inputs are asynchronous pins and the timing counts are static.
//
// How it works
// - Rails come up in order: logic, then gate-low, then gate-high with source.
// - Buck enable rises right after undervoltage lockout clears.
// - Buck power-good starts reset timer; expiry releases reset and enables negative pump.
// - Delay timer starts with negative pump; boost and positive pump wait for it.
// - Delay length is the programmed delay count plus one cycle, no fixed internal delay.
// - Undervoltage lockout drops every supply enable at once, no ordered shutdown.
// - Isolation switch gate goes low once the enable delay follows reset release.
// - One millisecond after gate low, source rail good enables the boost converter.
// - Source rail not good at that check raises error and keeps boost off.
// - Positive pump enters short-circuit mode together with gate going low.
// - Feedback threshold reached in short-circuit mode removes positive pump control current.
// - Boost switching moves the positive pump into normal regulation.
// - Normal regulation ramps the available positive pump current as soft-start.
// - Reset output to the timing controller is open-drain and active low.
// - Reset line is driven low during lockout and after it; it is released the programmed reset count after power-good.
// - Sequencing uses internal timing, or the enable pin in external enable mode; the reset line level is never read.
// - A zero reset count gives an almost zero reset wait.
// - In external enable mode the negative pump waits for the enable level.
`timescale 1ns/100ps
`default_nettype none

module lcd_bias_power_sequencer #(
  parameter int CHECK_CYCLES = lcd_bias_seq_pkg::CHECK_CYCLES
) (
  input  wire logic                                 ref_clk,
  input  wire logic                                 rst_b,
  input  wire logic                                 undervoltage_lockout,
  input  wire logic                                 buck_power_good,
  input  wire logic                                 source_rail_ok,
  input  wire logic                                 pos_pump_feedback,
  input  wire logic                                 boost_switching,
  input  wire logic                                 reset_timing_cap,
  input  wire logic                                 external_enable_mode,
  input  wire logic [lcd_bias_seq_pkg::TIMER_W-1:0] reset_pulse_count,
  input  wire logic [lcd_bias_seq_pkg::TIMER_W-1:0] enable_delay_count,
  input  wire logic                                 tcon_reset_in,
  output logic                                      tcon_reset_out,
  output logic                                      tcon_reset_oe_b,
  output logic                                      buck_enable,
  output logic                                      neg_pump_enable,
  output logic                                      iso_switch_gate,
  output logic                                      pos_pump_short_mode,
  output logic                                      pos_pump_normal,
  output logic                                      pos_pump_ctrl,
  output logic [lcd_bias_seq_pkg::SOFT_W-1:0]       pos_pump_soft_level,
  output logic                                      boost_enable,
  output logic                                      source_error
);

  // Lockout clears the whole sequencer without a clock edge.
  logic seq_rst_b;
  assign seq_rst_b = rst_b & ~undervoltage_lockout;

  // Pin synchronisers: four flops per pin, a change counts once stages two and three agree.
  logic [lcd_bias_seq_pkg::PIN_N-1:0] pin_raw;
  logic [lcd_bias_seq_pkg::PIN_N-1:0] sync1;
  logic [lcd_bias_seq_pkg::PIN_N-1:0] sync2;
  logic [lcd_bias_seq_pkg::PIN_N-1:0] sync3;
  logic [lcd_bias_seq_pkg::PIN_N-1:0] pin;
  logic [lcd_bias_seq_pkg::PIN_N-1:0] next_pin;

  assign pin_raw = {reset_timing_cap, boost_switching, pos_pump_feedback,
                    source_rail_ok, buck_power_good};

  genvar gi;
  generate
    for (gi = 0; gi < lcd_bias_seq_pkg::PIN_N; gi++) begin : g_pin
      always_comb begin
        next_pin[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : pin[gi];
      end
      // Lockout clears the chain too, so a stale power-good cannot skip the buck step.
      always_ff @(posedge ref_clk or negedge seq_rst_b) begin
        if (!seq_rst_b) begin
          sync1[gi] <= lcd_bias_seq_pkg::PIN_RESET[gi];
          sync2[gi] <= lcd_bias_seq_pkg::PIN_RESET[gi];
          sync3[gi] <= lcd_bias_seq_pkg::PIN_RESET[gi];
          pin[gi]   <= lcd_bias_seq_pkg::PIN_RESET[gi];
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          pin[gi]   <= next_pin[gi];
        end
      end
    end
  endgenerate

  lcd_bias_seq_pkg::seq_state_t state;
  lcd_bias_seq_pkg::seq_state_t next_state;
  logic [lcd_bias_seq_pkg::CNT_W-1:0]       cnt;
  logic [lcd_bias_seq_pkg::CNT_W-1:0]       next_cnt;
  logic [lcd_bias_seq_pkg::SOFT_STEP_W-1:0] soft_cnt;
  logic [lcd_bias_seq_pkg::SOFT_STEP_W-1:0] next_soft_cnt;
  logic                                     fb_reached;
  logic                                     next_fb_reached;
  logic next_buck_enable;
  logic next_neg_pump_enable;
  logic next_iso_switch_gate;
  logic next_short_mode;
  logic next_normal;
  logic next_ctrl;
  logic [lcd_bias_seq_pkg::SOFT_W-1:0] next_soft_level;
  logic next_boost_enable;
  logic next_source_error;
  logic next_reset_oe_b;
  logic reset_done;
  logic delay_done;
  logic check_done;

  // A zero count ends the reset wait on the first counted cycle.
  assign reset_done = external_enable_mode ? pin[lcd_bias_seq_pkg::PIN_EXT_EN]
                    : (cnt >= {2'b00, reset_pulse_count});
  assign delay_done = (cnt >= {2'b00, enable_delay_count});
  assign check_done = (cnt == lcd_bias_seq_pkg::CNT_W'(CHECK_CYCLES - 1));

  always_comb begin
    next_state           = state;
    next_cnt             = cnt + 1'b1;
    next_buck_enable     = 1'b1;
    next_neg_pump_enable = neg_pump_enable;
    next_iso_switch_gate = iso_switch_gate;
    next_short_mode      = pos_pump_short_mode;
    next_normal          = pos_pump_normal;
    next_boost_enable    = boost_enable;
    next_source_error    = source_error;
    next_reset_oe_b      = tcon_reset_oe_b;
    unique case (state)
      lcd_bias_seq_pkg::ST_BUCK: begin
        next_cnt = '0;
        if (pin[lcd_bias_seq_pkg::PIN_PGOOD]) begin
          next_state = lcd_bias_seq_pkg::ST_RESET;
        end
      end
      lcd_bias_seq_pkg::ST_RESET: begin
        if (reset_done) begin
          next_state           = lcd_bias_seq_pkg::ST_DELAY;
          next_cnt             = '0;
          next_neg_pump_enable = 1'b1;
          next_reset_oe_b      = 1'b1;
        end
      end
      lcd_bias_seq_pkg::ST_DELAY: begin
        if (delay_done) begin
          next_state           = lcd_bias_seq_pkg::ST_CHECK;
          next_cnt             = '0;
          next_iso_switch_gate = 1'b0;
          next_short_mode      = 1'b1;
        end
      end
      lcd_bias_seq_pkg::ST_CHECK: begin
        if (check_done) begin
          next_cnt = '0;
          if (pin[lcd_bias_seq_pkg::PIN_SRC_OK]) begin
            next_state        = lcd_bias_seq_pkg::ST_RUN;
            next_boost_enable = 1'b1;
          end else begin
            next_state        = lcd_bias_seq_pkg::ST_FAULT;
            next_source_error = 1'b1;
          end
        end
      end
      lcd_bias_seq_pkg::ST_RUN: begin
        next_cnt = '0;
        if (pin[lcd_bias_seq_pkg::PIN_BOOST_SW]) begin
          next_short_mode = 1'b0;
          next_normal     = 1'b1;
        end
      end
      lcd_bias_seq_pkg::ST_FAULT: begin
        next_cnt = '0;
      end
    endcase
  end

  // Positive pump current: cut once feedback shows no short, ramped in normal mode.
  always_comb begin
    next_fb_reached = fb_reached;
    if (pos_pump_short_mode && pin[lcd_bias_seq_pkg::PIN_FB_OK]) begin
      next_fb_reached = 1'b1;
    end
    next_ctrl = (next_short_mode && !next_fb_reached) || next_normal;
    next_soft_cnt   = soft_cnt;
    next_soft_level = pos_pump_soft_level;
    if (pos_pump_normal && pos_pump_soft_level != lcd_bias_seq_pkg::SOFT_FULL) begin
      if (soft_cnt == lcd_bias_seq_pkg::SOFT_STEP_W'(lcd_bias_seq_pkg::SOFT_STEP_CYCLES - 1)) begin
        next_soft_cnt   = '0;
        next_soft_level = pos_pump_soft_level + 1'b1;
      end else begin
        next_soft_cnt = soft_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge seq_rst_b) begin
    if (!seq_rst_b) begin
      state               <= lcd_bias_seq_pkg::ST_BUCK;
      cnt                 <= '0;
      soft_cnt            <= '0;
      fb_reached          <= 1'b0;
      buck_enable         <= 1'b0;
      neg_pump_enable     <= 1'b0;
      iso_switch_gate     <= lcd_bias_seq_pkg::GATE_OFF;
      pos_pump_short_mode <= 1'b0;
      pos_pump_normal     <= 1'b0;
      pos_pump_ctrl       <= 1'b0;
      pos_pump_soft_level <= lcd_bias_seq_pkg::SOFT_RESET;
      boost_enable        <= 1'b0;
      source_error        <= 1'b0;
      tcon_reset_oe_b     <= 1'b0;
      tcon_reset_out      <= 1'b0;
    end else begin
      state               <= next_state;
      cnt                 <= next_cnt;
      soft_cnt            <= next_soft_cnt;
      fb_reached          <= next_fb_reached;
      buck_enable         <= next_buck_enable;
      neg_pump_enable     <= next_neg_pump_enable;
      iso_switch_gate     <= next_iso_switch_gate;
      pos_pump_short_mode <= next_short_mode;
      pos_pump_normal     <= next_normal;
      pos_pump_ctrl       <= next_ctrl;
      pos_pump_soft_level <= next_soft_level;
      boost_enable        <= next_boost_enable;
      source_error        <= next_source_error;
      tcon_reset_oe_b     <= next_reset_oe_b;
      tcon_reset_out      <= 1'b0;
    end
  end

  // Checks.
  a_buck_first: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    neg_pump_enable |-> buck_enable) else $error("negative pump on before buck");

  a_gate_order: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    !iso_switch_gate |-> neg_pump_enable) else $error("gate low before negative pump");

  a_buck_on: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    !buck_enable |=> buck_enable) else $error("buck not enabled after lockout");

  a_reset_pulse: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    $rose(neg_pump_enable) |-> $rose(tcon_reset_oe_b)) else $error("reset and pump split");

  a_delay_len: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    ($rose(neg_pump_enable) && enable_delay_count == 16'h0003)
      |-> iso_switch_gate [*4] ##1 !iso_switch_gate) else $error("delay length wrong");

  a_short_mode: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    $fell(iso_switch_gate) |-> $rose(pos_pump_short_mode)) else $error("short mode late");

  a_boost_gate: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    $rose(boost_enable) |-> !iso_switch_gate && $past(pin[lcd_bias_seq_pkg::PIN_SRC_OK]))
    else $error("boost enabled without source check");

  a_error_hold: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    source_error |-> !boost_enable ##1 source_error) else $error("error lost or boost on");

  a_fb_cut: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    (pos_pump_short_mode && fb_reached && !pos_pump_normal) |-> !pos_pump_ctrl)
    else $error("pump current on after feedback threshold");

  a_soft_ramp: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    !pos_pump_normal |-> pos_pump_soft_level == lcd_bias_seq_pkg::SOFT_RESET)
    else $error("soft-start ramped outside normal mode");

  a_normal_ctrl: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    pos_pump_normal |-> pos_pump_ctrl && !pos_pump_short_mode)
    else $error("normal mode without pump current");

  a_ext_wait: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    (external_enable_mode && state == lcd_bias_seq_pkg::ST_RESET
      && !pin[lcd_bias_seq_pkg::PIN_EXT_EN]) |=> !neg_pump_enable)
    else $error("negative pump on before external enable");

  a_soft_step: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    (pos_pump_normal && $changed(pos_pump_soft_level))
      |-> pos_pump_soft_level == $past(pos_pump_soft_level) + 8'h01)
    else $error("soft-start level jumped");

  a_error_gate: assert property (@(posedge ref_clk) disable iff (!seq_rst_b)
    $rose(source_error) |-> !$past(pin[lcd_bias_seq_pkg::PIN_SRC_OK]) && !boost_enable)
    else $error("error raised with source rail good");

  // Main scenarios: hand-over, source fault, external enable, long reset, reset line held low.
  c_full_run: cover property (@(posedge ref_clk) disable iff (!seq_rst_b)
    $rose(pos_pump_normal));
  c_fault: cover property (@(posedge ref_clk) disable iff (!seq_rst_b)
    $rose(source_error));
  c_ext_enable: cover property (@(posedge ref_clk) disable iff (!seq_rst_b)
    external_enable_mode && $rose(neg_pump_enable) && !tcon_reset_in);
  c_long_reset: cover property (@(posedge ref_clk) disable iff (!seq_rst_b)
    $rose(neg_pump_enable) && reset_pulse_count != 16'h0000);
  c_held_low: cover property (@(posedge ref_clk) disable iff (!seq_rst_b)
    $rose(boost_enable) && !tcon_reset_in);

endmodule // lcd_bias_power_sequencer

`default_nettype wire

// >>> design/lcd_bias_seq_pkg.sv
// Constants and state type for the LCD bias power sequencer.
// Assumes a single 250 MHz clock; timer counts stand in for external capacitors.
package lcd_bias_seq_pkg;

  localparam int CLK_MHZ = 250;

  // Source rail check interval after the isolation switch gate goes low.
  localparam int CHECK_TIME_US = 1000;
  localparam int CHECK_CYCLES = CHECK_TIME_US * CLK_MHZ;

  // Soft-start: cycles spent on each step of the positive pump current ramp.
  localparam int SOFT_STEP_CYCLES = 16;

  localparam int CNT_W = 18;
  localparam int TIMER_W = 16;
  localparam int SOFT_W = 8;
  localparam int SOFT_STEP_W = 5;
  localparam int PIN_N = 5;

  // Bit positions of the synchronised pin inputs.
  localparam int PIN_PGOOD = 0;
  localparam int PIN_SRC_OK = 1;
  localparam int PIN_FB_OK = 2;
  localparam int PIN_BOOST_SW = 3;
  localparam int PIN_EXT_EN = 4;

  // Values after reset, and the soft-start full level.
  localparam logic GATE_OFF = 1'b1;
  localparam logic [SOFT_W-1:0] SOFT_RESET = 8'h00;
  localparam logic [SOFT_W-1:0] SOFT_FULL = 8'hff;
  localparam logic [PIN_N-1:0] PIN_RESET = 5'h00;

  typedef enum logic [2:0] {
    ST_BUCK,
    ST_RESET,
    ST_DELAY,
    ST_CHECK,
    ST_RUN,
    ST_FAULT
  } seq_state_t;

endpackage

// >>> dv/bias_stage_model.sv
// Behavioural model of the converter stages and of the reset line pull-up.
// Assumes the sequencer outputs; the bench commands src_fail and hold_low.
`timescale 1ns/100ps
`default_nettype none

module bias_stage_model (
  input  wire logic ref_clk,
  input  wire logic buck_enable,
  input  wire logic iso_switch_gate,
  input  wire logic pos_pump_short_mode,
  input  wire logic boost_enable,
  input  wire logic tcon_reset_out,
  input  wire logic tcon_reset_oe_b,
  input  wire logic src_fail,
  input  wire logic hold_low,
  output logic      buck_power_good,
  output logic      source_rail_ok,
  output logic      pos_pump_feedback,
  output logic      boost_switching,
  output logic      tcon_reset_in
);
  logic [2:0] pg_d = 3'h0;
  logic [4:0] src_d = 5'h00;
  logic [2:0] fb_d = 3'h0;
  logic [1:0] bs_d = 2'h0;

  // Each stage answers a few cycles after it is enabled, as a real rail ramps.
  always @(negedge ref_clk) begin
    pg_d <= {pg_d[1:0], buck_enable};
    src_d <= {src_d[3:0], !iso_switch_gate && !src_fail};
    fb_d <= {fb_d[1:0], pos_pump_short_mode};
    bs_d <= {bs_d[0], boost_enable};
  end

  assign buck_power_good = pg_d[2];
  assign source_rail_ok = src_d[4];
  assign pos_pump_feedback = fb_d[2];
  assign boost_switching = bs_d[1];
  // A released line floats up to the pull-up unless something holds it low.
  assign tcon_reset_in = hold_low ? 1'b0 : (tcon_reset_oe_b ? 1'b1 : tcon_reset_out);
endmodule // bias_stage_model

`default_nettype wire

// >>> dv/lcd_bias_power_sequencer_tb_top.sv
// Self-checking bench for the LCD bias power sequencer.
// Assumes the stage model on the far side; timing is checked by edge stamps.
`timescale 1ns/100ps
`default_nettype none

module lcd_bias_power_sequencer_tb_top;
  localparam int CHK = 20;
  logic ref_clk = 1'b0, rst_b = 1'b0, undervoltage_lockout = 1'b0;
  logic buck_power_good, source_rail_ok, pos_pump_feedback, boost_switching;
  logic reset_timing_cap = 1'b0, external_enable_mode = 1'b0, tcon_reset_in;
  logic [15:0] reset_pulse_count = 16'h0000, enable_delay_count = 16'h0000;
  logic tcon_reset_out, tcon_reset_oe_b, buck_enable, neg_pump_enable, iso_switch_gate;
  logic pos_pump_short_mode, pos_pump_normal, pos_pump_ctrl, boost_enable, source_error;
  logic [7:0] pos_pump_soft_level, lvl;
  logic src_fail = 1'b0, hold_low = 1'b0, sh_at_gate, ctrl_off;
  int cyc = 0, n_mismatch = 0, comparisons = 0, lat0 = 0, t_cap = 0;
  int t_pg, t_neg, t_rst, t_gate, t_boost, t_err;

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  lcd_bias_power_sequencer #(.CHECK_CYCLES(CHK)) lcd_bias_power_sequencer_i (.*);
  bias_stage_model bias_stage_model_i (.*);

  // Stamps the cycle of power-good, the first rise of negative pump, reset release, boost and error, and the gate's first fall.
  always @(negedge ref_clk) begin
    if (buck_power_good && t_pg < 0) t_pg = cyc;
    if (neg_pump_enable && t_neg < 0) t_neg = cyc;
    if (tcon_reset_oe_b && t_rst < 0) t_rst = cyc;
    if (!iso_switch_gate && t_gate < 0) begin
      t_gate = cyc;
      sh_at_gate = pos_pump_short_mode;
    end
    if (boost_enable && t_boost < 0) t_boost = cyc;
    if (source_error && t_err < 0) t_err = cyc;
    if (pos_pump_short_mode && !pos_pump_ctrl) ctrl_off = 1'b1;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task restart(input logic [15:0] rc, input logic [15:0] dc, input logic ext, input logic fl);
    @(negedge ref_clk);
    undervoltage_lockout = 1'b1;
    reset_pulse_count = rc;
    enable_delay_count = dc;
    external_enable_mode = ext;
    src_fail = fl;
    repeat (4) @(negedge ref_clk);
    {t_pg, t_neg, t_rst, t_gate, t_boost, t_err} = {6{-32'sd1}};
    ctrl_off = 1'b0;
    undervoltage_lockout = 1'b0;
    @(negedge ref_clk);
    chk(buck_enable, 1'b1);
    chk(tcon_reset_oe_b, 1'b0);
    chk(tcon_reset_out, 1'b0);
    chk(tcon_reset_in, 1'b0);
  endtask

  task t_basic;
    restart(16'h0000, 16'h0003, 1'b0, 1'b0);
    repeat (50) @(negedge ref_clk);
    lat0 = t_neg - t_pg;
    chk(16'(t_gate - t_neg), 16'h0004);
    chk(16'(t_rst - t_neg), 16'h0000);
    chk(tcon_reset_in, 1'b1);
    chk(sh_at_gate, 1'b1);
    chk(ctrl_off, 1'b1);
    chk(t_boost - t_gate >= CHK && t_boost - t_gate <= CHK + 2, 1'b1);
    chk(t_pg < t_neg && t_neg < t_gate && t_gate < t_boost, 1'b1);
    chk({pos_pump_normal, pos_pump_short_mode, pos_pump_ctrl}, 3'h5);
    lvl = pos_pump_soft_level;
    repeat (32) @(negedge ref_clk);
    chk(pos_pump_soft_level - lvl, 8'h02);
    chk(source_error, 1'b0);
    $display("test basic done");
  endtask

  task t_long;
    hold_low = 1'b1;
    restart(16'h000a, 16'h0000, 1'b0, 1'b0);
    repeat (80) @(negedge ref_clk);
    chk(16'(t_neg - t_pg), 16'(lat0 + 10));
    chk(16'(t_gate - t_neg), 16'h0001);
    chk(boost_enable, 1'b1);
    hold_low = 1'b0;
    $display("test long reset done");
  endtask

  task t_fail;
    restart(16'h0000, 16'h0000, 1'b0, 1'b1);
    repeat (60) @(negedge ref_clk);
    chk(t_err - t_gate >= CHK && t_err - t_gate <= CHK + 2, 1'b1);
    chk(boost_enable, 1'b0);
    $display("test source fail done");
  endtask

  task t_ext;
    hold_low = 1'b1;
    restart(16'h0000, 16'h0002, 1'b1, 1'b0);
    repeat (60) @(negedge ref_clk);
    chk(neg_pump_enable, 1'b0);
    reset_timing_cap = 1'b1;
    t_cap = cyc;
    repeat (60) @(negedge ref_clk);
    chk(t_neg - t_cap >= 1 && t_neg - t_cap <= 6, 1'b1);
    chk(16'(t_gate - t_neg), 16'h0003);
    chk(boost_enable, 1'b1);
    chk(tcon_reset_in, 1'b0);
    hold_low = 1'b0;
    $display("test external enable done");
  endtask

  task t_undervoltage_lockout;
    @(negedge ref_clk);
    undervoltage_lockout = 1'b1;
    #1;
    chk({buck_enable, neg_pump_enable, iso_switch_gate, pos_pump_short_mode,
         pos_pump_normal, pos_pump_ctrl, boost_enable, source_error}, 8'h20);
    chk({tcon_reset_oe_b, pos_pump_soft_level}, 9'h000);
    reset_timing_cap = 1'b0;
    $display("test lockout done");
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #10000;
    n_mismatch++;
    results();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    t_basic();
    t_long();
    t_fail();
    t_ext();
    t_undervoltage_lockout();
    results();
  end
endmodule // lcd_bias_power_sequencer_tb_top

`default_nettype wire
